//--- pkg/eeprom_regs.svh
// constants for the two-wire eeprom slave: codes, widths and timing
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

`define CTRL_TYPE_CODE 4'hA
`define WORD_ADDR_BITS 13
`define PAGE_PTR_BITS 5
`define HI_ADDR_USED_BITS 5
`define BITS_PER_BYTE 4'h8
`define ACK_SLOT_IDX 4'h8
`define LAST_DATA_BIT_IDX 4'h7
`define REF_CLK_MHZ 250
`define WRITE_TIME_MS 5
`define WRITE_CYCLES_DFLT (`WRITE_TIME_MS * 1000 * `REF_CLK_MHZ)

`endif

//--- pkg/eeprom_slave_pkg.sv
// types shared by the two-wire eeprom slave
package eeprom_slave_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_DATA,
    ST_IGNORE
  } slave_state_t;

  typedef struct packed {
    logic [3:0] type_code;
    logic [2:0] chip_sel;
    logic read_dir;
  } ctrl_byte_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } line_sample_t;

endpackage

//--- logic/eeprom_write_slave.sv
// two-wire serial eeprom slave: addressing, page buffer and write cycle
//
// Summary of operation
// - sda falling with scl high is start, rising is stop
// - sda only changes while scl is low; high phases carry bits
// - one scl pulse per bit, no extra pulses within a byte
// - each received byte gets an acknowledge in a ninth slot; the slave gives none after a foreign or read control byte, or while busy
// - acknowledge holds sda low across the whole ninth high phase
// - on read end without acknowledge, slave releases sda for stop
// - first byte after start is control; top nibble must be 1010
// - three chip-select bits must match the chip-select inputs
// - control byte lsb: one means read, zero means write
// - two address bytes follow, high first; top three bits ignored
// - acknowledge matching control byte and each address and data byte
// - stop after write data launches the self-timed program cycle
// - no acknowledge at all while a program cycle is running
// - program cycle for a byte or page ends within write time
// - write protect high: acknowledge, no programming, ready at once
// - after a write the pointer holds the next location
// - a partial page write rewrites the whole page unchanged
// - buffer first byte plus up to 31 more; commit only at stop
// - only the five low pointer bits count; wrap within the page
// - beyond a page only the latest thirty-two bytes are kept
// - write protect sampled at stop; later changes are ignored
// - pointer stays inside this device's own array
`timescale 1ns/100ps
`include "eeprom_regs.svh"

module eeprom_write_slave #(
  parameter int ADDR_BITS = `WORD_ADDR_BITS,
  parameter int PAGE_BITS = `PAGE_PTR_BITS,
  parameter int WRITE_CYCLES = `WRITE_CYCLES_DFLT
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic chip_select_in_0,
  input wire logic chip_select_in_1,
  input wire logic chip_select_in_2,
  input wire logic write_protect_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic write_busy_out,
  output logic [ADDR_BITS-1:0] addr_ptr_out
);
  import eeprom_slave_pkg::*;

  localparam int ARRAY_BYTES = 2 ** ADDR_BITS;
  localparam int PAGE_BYTES = 2 ** PAGE_BITS;
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES - 1);

  // ----------------------------------------------------------------
  // link domain: sda sampled on the rising edge of scl
  // ----------------------------------------------------------------
  // scl only runs during frames, so these need no reset; the sampled
  // bit holds until the next rise, long after the toggle has crossed
  logic link_bit_r = 1'b0;
  logic link_tgl_r = 1'b0;

  always_ff @(posedge scl_in) begin
    link_bit_r <= sda_in;
    link_tgl_r <= ~link_tgl_r;
  end

  // ----------------------------------------------------------------
  // reference domain: pin synchronisers and line events
  // ----------------------------------------------------------------
  line_sample_t line_s1_r;
  line_sample_t line_s2_r;
  line_sample_t line_d_r;
  logic [2:0] cs_s1_r;
  logic [2:0] cs_s2_r;
  logic wp_s1_r;
  logic wp_s2_r;
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_d_r;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      line_s1_r <= '{scl: 1'b1, sda: 1'b1};
      line_s2_r <= '{scl: 1'b1, sda: 1'b1};
      line_d_r <= '{scl: 1'b1, sda: 1'b1};
      cs_s1_r <= 3'h0;
      cs_s2_r <= 3'h0;
      wp_s1_r <= 1'b0;
      wp_s2_r <= 1'b0;
    end else begin
      line_s1_r <= '{scl: scl_in, sda: sda_in};
      line_s2_r <= line_s1_r;
      line_d_r <= line_s2_r;
      cs_s1_r <= {chip_select_in_2, chip_select_in_1, chip_select_in_0};
      cs_s2_r <= cs_s1_r;
      wp_s1_r <= write_protect_in;
      wp_s2_r <= wp_s1_r;
    end
  end

  // the toggle history follows the crossed value through reset, so no
  // false bit appears on release whatever the toggle happened to be
  always_ff @(posedge ref_clk_in) begin
    tgl_s1_r <= link_tgl_r;
    tgl_s2_r <= tgl_s1_r;
    tgl_d_r <= tgl_s2_r;
  end

  logic start_evt;
  logic stop_evt;
  logic scl_fall;
  logic bit_evt;

  assign start_evt = line_s2_r.scl & line_d_r.scl & line_d_r.sda
                     & ~line_s2_r.sda;
  assign stop_evt = line_s2_r.scl & line_d_r.scl & ~line_d_r.sda
                    & line_s2_r.sda;
  assign scl_fall = line_d_r.scl & ~line_s2_r.scl;
  assign bit_evt = tgl_s2_r ^ tgl_d_r;

  // ----------------------------------------------------------------
  // bit counter and byte assembly
  // ----------------------------------------------------------------
  slave_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] byte_w;
  logic byte_done;
  ctrl_byte_t ctrl_w;
  logic busy_r;

  assign byte_w = {shift_r[6:0], link_bit_r};
  assign ctrl_w = ctrl_byte_t'(byte_w);
  assign byte_done = bit_evt && (state_r != ST_IDLE)
                     && (bit_cnt_r == `LAST_DATA_BIT_IDX);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
    end else if (start_evt || stop_evt) begin
      bit_cnt_r <= 4'h0;
    end else if (bit_evt && state_r != ST_IDLE) begin
      if (bit_cnt_r == `ACK_SLOT_IDX) begin
        bit_cnt_r <= 4'h0;
      end else begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
        shift_r <= byte_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // command sequencing
  // ----------------------------------------------------------------
  logic ctrl_match;
  logic [ADDR_BITS-1:0] addr_r;
  logic got_data_r;

  assign ctrl_match = (ctrl_w.type_code == `CTRL_TYPE_CODE)
                      && (ctrl_w.chip_sel == cs_s2_r);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_r <= ST_IDLE;
    end else if (start_evt) begin
      state_r <= ST_CTRL;
    end else if (stop_evt) begin
      state_r <= ST_IDLE;
    end else if (byte_done) begin
      case (state_r)
        ST_CTRL: begin
          if (ctrl_match && !busy_r && !ctrl_w.read_dir) begin
            state_r <= ST_ADDR_HI;
          end else begin
            state_r <= ST_IGNORE;
          end
        end
        ST_ADDR_HI: begin
          state_r <= ST_ADDR_LO;
        end
        ST_ADDR_LO: begin
          state_r <= ST_DATA;
        end
        ST_DATA, ST_IGNORE: begin
          state_r <= state_r;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // reads are acknowledged but not served; the slave then keeps sda
  // released, so a master that ends without acknowledge can stop.
  logic ack_due;

  always_comb begin
    ack_due = 1'b0;
    case (state_r)
      ST_CTRL: begin
        ack_due = ctrl_match;
      end
      ST_ADDR_HI, ST_ADDR_LO, ST_DATA: begin
        ack_due = 1'b1;
      end
      default: begin
        ack_due = 1'b0;
      end
    endcase
    if (busy_r) begin
      ack_due = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // acknowledge drive
  // ----------------------------------------------------------------
  logic ack_pend_r;
  logic sda_oe_r;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in || start_evt || stop_evt) begin
      ack_pend_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (byte_done) begin
      ack_pend_r <= ack_due;
    end else if (scl_fall) begin
      if (sda_oe_r) begin
        sda_oe_r <= 1'b0;
      end else if (ack_pend_r) begin
        sda_oe_r <= 1'b1;
        ack_pend_r <= 1'b0;
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe_r;

  // ----------------------------------------------------------------
  // address pointer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      addr_r <= '0;
      got_data_r <= 1'b0;
    end else if (start_evt) begin
      got_data_r <= 1'b0;
    end else if (byte_done) begin
      case (state_r)
        ST_ADDR_HI: begin
          addr_r[ADDR_BITS-1:8] <= byte_w[ADDR_BITS-9:0];
        end
        ST_ADDR_LO: begin
          addr_r[7:0] <= byte_w;
          got_data_r <= 1'b0;
        end
        ST_DATA: begin
          addr_r[PAGE_BITS-1:0] <= addr_r[PAGE_BITS-1:0]
                                   + PAGE_BITS'(1);
          got_data_r <= 1'b1;
        end
        default: begin
          got_data_r <= got_data_r;
        end
      endcase
    end
  end

  assign addr_ptr_out = addr_r;

  // ----------------------------------------------------------------
  // page buffer and array
  // ----------------------------------------------------------------
  // the buffer is filled from the array when the address completes,
  // so a commit always writes back a whole page
  logic [7:0] mem_r [0:ARRAY_BYTES-1];
  logic [7:0] page_buf_r [0:PAGE_BYTES-1];
  logic [ADDR_BITS-PAGE_BITS-1:0] load_page;
  logic [ADDR_BITS-PAGE_BITS-1:0] prog_page_r;
  logic prog_done;

  assign load_page = {addr_r[ADDR_BITS-1:8], byte_w[7:PAGE_BITS]};

  genvar gi;
  generate
    for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_page
      always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
          page_buf_r[gi] <= 8'h00;
        end else if (byte_done && state_r == ST_ADDR_LO) begin
          page_buf_r[gi] <= mem_r[{load_page, PAGE_BITS'(gi)}];
        end else if (byte_done && state_r == ST_DATA
                     && addr_r[PAGE_BITS-1:0] == PAGE_BITS'(gi)) begin
          page_buf_r[gi] <= byte_w;
        end
      end
    end
  endgenerate

  // array contents survive reset, as a non-volatile store would
  always_ff @(posedge ref_clk_in) begin
    if (prog_done) begin
      for (int j = 0; j < PAGE_BYTES; j++) begin
        mem_r[{prog_page_r, PAGE_BITS'(j)}] <= page_buf_r[j];
      end
    end
  end

  // ----------------------------------------------------------------
  // self-timed write cycle
  // ----------------------------------------------------------------
  logic launch;
  logic [CNT_W-1:0] wt_cnt_r;

  assign launch = stop_evt && state_r == ST_DATA && got_data_r
                  && !busy_r && !wp_s2_r;
  assign prog_done = busy_r && (wt_cnt_r == CNT_LAST);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      busy_r <= 1'b0;
      wt_cnt_r <= '0;
      prog_page_r <= '0;
    end else if (launch) begin
      busy_r <= 1'b1;
      wt_cnt_r <= '0;
      prog_page_r <= addr_r[ADDR_BITS-1:PAGE_BITS];
    end else if (prog_done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      wt_cnt_r <= wt_cnt_r + CNT_W'(1);
    end
  end

  assign write_busy_out = busy_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_busy_no_ack:
  assert property (@(posedge ref_clk_in) disable iff (reset_in)
    busy_r |-> !sda_oe_r && !ack_pend_r)
    else $error("acknowledge seen during write cycle");

  chk_cycle_bound:
  assert property (@(posedge ref_clk_in) disable iff (reset_in)
    wt_cnt_r <= CNT_LAST)
    else $error("write cycle counter ran past its bound");

  chk_stop_launch:
  assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (stop_evt && state_r == ST_DATA && got_data_r && !busy_r && !wp_s2_r)
    |=> busy_r && wt_cnt_r == '0)
    else $error("stop after data did not start a write cycle");

  chk_protect_idle:
  assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (stop_evt && wp_s2_r && !busy_r) |=> !busy_r)
    else $error("write cycle started while protected");

  chk_page_wrap:
  assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (byte_done && state_r == ST_DATA) |=>
    addr_r[ADDR_BITS-1:PAGE_BITS] == $past(addr_r[ADDR_BITS-1:PAGE_BITS])
    && addr_r[PAGE_BITS-1:0] == $past(addr_r[PAGE_BITS-1:0]) + 1'b1)
    else $error("pointer left its page");

  chk_start_abandon:
  assert property (@(posedge ref_clk_in) disable iff (reset_in)
    start_evt |=> state_r == ST_CTRL && bit_cnt_r == 4'h0 && !sda_oe_r)
    else $error("start did not restart the command");

  chk_ctrl_mismatch:
  assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (byte_done && state_r == ST_CTRL && !ctrl_match)
    |=> !ack_pend_r && state_r == ST_IGNORE)
    else $error("acknowledge pending for foreign control byte");

  chk_ack_hold:
  assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $fell(sda_oe_r) |-> $past(scl_fall) || $past(start_evt)
    || $past(stop_evt))
    else $error("acknowledge released while scl was high");

  chk_ack_slot:
  assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $rose(sda_oe_r) |-> bit_cnt_r == `ACK_SLOT_IDX)
    else $error("acknowledge driven outside the ninth slot");

  chk_cycle_hold:
  assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $rose(busy_r) |=> busy_r [*8])
    else $error("write cycle cut short");

endmodule

//--- verification/eeprom_bus_master.sv
// two-wire bus master model that drives scl and pulls sda low
`timescale 1ns/100ps

module eeprom_bus_master (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  // ------------------------------------------------------------
  // line drive
  // ------------------------------------------------------------
  // scl stands high between frames; a released sda is pulled up
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end

  // one bit: data moves mid low phase, high phase lasts 15 ns
  task automatic put_bit(input logic b, input int lo, output logic seen);
    #(lo / 2) sda_pull_out = ~b;
    #(lo - lo / 2) scl_out = 1'b1;
    #1 seen = sda_in;
    #13 seen = seen | sda_in;
    #1 scl_out = 1'b0;
  endtask

  task automatic start_cond();
    #7 sda_pull_out = 1'b0;
    #8 scl_out = 1'b1;
    #15 sda_pull_out = 1'b1;
    #15 scl_out = 1'b0;
  endtask

  task automatic stop_cond();
    #7 sda_pull_out = 1'b1;
    #8 scl_out = 1'b1;
    #15 sda_pull_out = 1'b0;
    #15;
  endtask

  // longer low phases around the ack slot leave room for the
  // slave's clock crossing on both sides of the ninth pulse
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], 15, s);
    end
    put_bit(1'b1, 30, s);
    acked = ~s;
    #15;
  endtask
endmodule

//--- verification/test_serial_eeprom_addressing_write.sv
// self-checking bench for the two-wire eeprom write slave
`timescale 1ns/100ps

module test_serial_eeprom_addressing_write;
  import eeprom_slave_pkg::*;
  localparam int WC = 200;
  localparam logic [2:0] CS = 3'h5;
  logic ref_clk_in, reset_in, write_protect_in, ack;
  logic scl, sda, m_pull, sda_out, sda_oe_out, write_busy_out;
  logic [2:0] cs;
  logic [12:0] addr_ptr_out;
  int err_count, checks_done;
  realtime t0;

  // open drain wire: low while either party pulls
  assign sda = ~(m_pull | (sda_oe_out & ~sda_out));

  eeprom_write_slave #(.WRITE_CYCLES(WC)) eeprom_write_slave_inst (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .scl_in(scl),
    .sda_in(sda), .chip_select_in_0(cs[0]), .chip_select_in_1(cs[1]),
    .chip_select_in_2(cs[2]), .write_protect_in(write_protect_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .write_busy_out(write_busy_out), .addr_ptr_out(addr_ptr_out)
  );

  eeprom_bus_master eeprom_bus_master_inst (
    .sda_in(sda), .scl_out(scl), .sda_pull_out(m_pull)
  );

  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // ------------------------------------------------------------
  // compare and access tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_flag(input string what, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic check_word(input string what, input logic [12:0] e,
                            input logic [12:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] e,
                            input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  // the array has no port; its cells are looked at in place
  function automatic logic [7:0] mem_at(input logic [12:0] a);
    return eeprom_write_slave_inst.mem_r[a];
  endfunction

  function automatic logic [7:0] ctrl(input logic [2:0] c, input logic rd);
    ctrl_byte_t b;
    b.type_code = 4'hA;
    b.chip_sel = c;
    b.read_dir = rd;
    return b;
  endfunction

  task automatic byte_out(input logic [7:0] b, input logic e, input string w);
    eeprom_bus_master_inst.send_byte(b, ack);
    check_flag(w, e, ack);
  endtask

  task automatic head(input logic [7:0] hi, input logic [7:0] lo);
    eeprom_bus_master_inst.start_cond();
    byte_out(ctrl(CS, 1'b0), 1'b1, "ctrl ack");
    byte_out(hi, 1'b1, "addr hi ack");
    byte_out(lo, 1'b1, "addr lo ack");
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (write_busy_out !== lvl) begin
      @(negedge ref_clk_in);
      n++;
      if (n > 400) begin
        err_count++;
        $display("[FAIL] busy wait expected %b seen timeout", lvl);
        test_done();
      end
    end
  endtask

  // program cycle; with poll set, the bus is tried while it runs
  task automatic prog(input bit poll);
    wait_busy(1'b1);
    t0 = $realtime;
    if (poll) begin
      eeprom_bus_master_inst.start_cond();
      byte_out(ctrl(CS, 1'b0), 1'b0, "ctrl while busy");
      eeprom_bus_master_inst.stop_cond();
      @(negedge ref_clk_in);
      write_protect_in = 1'b1;
    end
    wait_busy(1'b0);
    check_flag("cycle length", 1'b1, ($realtime - t0) >= (WC - 3) * 4.0
               && ($realtime - t0) <= (WC + 3) * 4.0);
    @(negedge ref_clk_in);
    write_protect_in = 1'b0;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    err_count = 0;
    checks_done = 0;
    reset_in = 1'b1;
    write_protect_in = 1'b0;
    cs = CS;
    repeat (20) @(negedge ref_clk_in);
    reset_in = 1'b0;
    repeat (8) @(negedge ref_clk_in);
    check_flag("busy after reset", 1'b0, write_busy_out);
    check_word("ptr after reset", 13'h0000, addr_ptr_out);
    // byte write; protect raised mid cycle must not stop it
    head(8'hE5, 8'h43);
    byte_out(8'h5A, 1'b1, "data ack");
    eeprom_bus_master_inst.stop_cond();
    prog(1'b1);
    check_word("ptr byte write", 13'h0544, addr_ptr_out);
    check_byte("mem byte write", 8'h5A, mem_at(13'h0543));
    // every chip-select pattern; control-only commands never program
    for (int k = 0; k < 8; k++) begin
      eeprom_bus_master_inst.start_cond();
      byte_out(ctrl(k[2:0], 1'b0), k[2:0] == CS, "cs match");
      eeprom_bus_master_inst.stop_cond();
    end
    eeprom_bus_master_inst.start_cond();
    byte_out({4'hB, CS, 1'b0}, 1'b0, "bad type code");
    eeprom_bus_master_inst.stop_cond();
    check_flag("busy addr only", 1'b0, write_busy_out);
    // page end wrap at the top of the array
    head(8'h1F, 8'hFE);
    for (int i = 0; i < 3; i++) begin
      byte_out(8'(i), 1'b1, "page ack");
    end
    eeprom_bus_master_inst.stop_cond();
    prog(1'b0);
    check_word("ptr page wrap", 13'h1FE1, addr_ptr_out);
    check_byte("mem page end", 8'h01, mem_at(13'h1FFF));
    check_byte("mem wrap head", 8'h02, mem_at(13'h1FE0));
    // 33 bytes: buffered until stop, pointer rolls over once
    head(8'h00, 8'h40);
    for (int i = 0; i < 33; i++) begin
      byte_out(8'(i + 1), 1'b1, "long page ack");
    end
    check_flag("busy before stop", 1'b0, write_busy_out);
    eeprom_bus_master_inst.stop_cond();
    prog(1'b0);
    check_word("ptr overflow", 13'h0041, addr_ptr_out);
    check_byte("mem overwrite", 8'h21, mem_at(13'h0040));
    check_byte("mem page tail", 8'h20, mem_at(13'h005F));
    // protected write: acknowledged, no cycle, next command at once
    @(negedge ref_clk_in);
    write_protect_in = 1'b1;
    head(8'h00, 8'h41);
    byte_out(8'hC3, 1'b1, "protected data ack");
    eeprom_bus_master_inst.stop_cond();
    repeat (20) @(negedge ref_clk_in);
    check_flag("busy protected", 1'b0, write_busy_out);
    check_byte("mem protected", 8'h02, mem_at(13'h0041));
    eeprom_bus_master_inst.start_cond();
    byte_out(ctrl(CS, 1'b0), 1'b1, "ctrl after protect");
    eeprom_bus_master_inst.stop_cond();
    @(negedge ref_clk_in);
    write_protect_in = 1'b0;
    // read direction is acknowledged, nothing after it
    eeprom_bus_master_inst.start_cond();
    byte_out(ctrl(CS, 1'b1), 1'b1, "read ctrl ack");
    byte_out(8'h00, 1'b0, "byte after read");
    eeprom_bus_master_inst.stop_cond();
    // start in mid byte abandons the command
    head(8'h03, 8'h20);
    for (int i = 0; i < 3; i++) begin
      eeprom_bus_master_inst.put_bit(1'b0, 15, ack);
    end
    head(8'h00, 8'h48);
    byte_out(8'h77, 1'b1, "data after restart");
    eeprom_bus_master_inst.stop_cond();
    prog(1'b0);
    check_word("ptr after restart", 13'h0049, addr_ptr_out);
    check_byte("mem restart data", 8'h77, mem_at(13'h0048));
    check_byte("mem page refresh", 8'h0A, mem_at(13'h0049));
    check_byte("mem protect kept", 8'h02, mem_at(13'h0041));
    test_done();
  end
endmodule
